// [src/pio_line_ctrl.sv]
/*
 per-line control of a 32-line parallel i/o port: change interrupts,
 open-drain, pull-ups, peripheral function choice, direct output writes.
 assumes one clock, synchronous reset and an avalon-mm master that holds
 each request until waitrequest is seen low.
*/
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
// Contract
// (R1) writing one to irq disable turns off that line's change interrupt
// (R2) irq mask reads one where change interrupt is enabled
// (R3) change status holds one where a level change happened since read
// (R4) reset clears all change bits; reading change status clears only the bits that the read returned
// (R5) writing one to open-drain enable makes that line open-drain
// (R6) writing one to open-drain disable returns line to push-pull
// (R7) open-drain state reads one for open-drain lines, zero push-pull
// (R8) writing one to pull-up disable switches that pull-up off
// (R9) writing one to pull-up enable switches that pull-up on
// (R10) pull-up state reads zero when enabled, one when disabled
// (R11) writing one to first-function select routes line to function one
// (R12) writing one to second-function select routes line to function two
// (R13) function state reads zero for first, one for second function
// (R14) writing one to direct-write enable lets output data writes land
// (R15) writing one to direct-write disable blocks output data writes
// (R16) direct-write state reads one where output data writes land
// (R17) writing one to irq enable turns on that line's change interrupt
// (R18) each enable/disable pair sets or clears one per-line state bit
// (R19) interrupt output high while a change bit and its mask bit are set
module pio_line_ctrl
   import pio_line_pkg::*;
#(
   parameter int LINES = `LINES
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire bus_req_t bus_req,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire lines_t pad_in,
   input wire lines_t periph_a_out,
   input wire lines_t periph_a_oe,
   input wire lines_t periph_b_out,
   input wire lines_t periph_b_oe,
   input wire lines_t periph_sel,
   output pad_ctl_t pad_ctl,
   output lines_t line_level,
   output logic irq
);

   // registered state and its next value
   state_t s_q;
   state_t s_d;

   // write data after byte lane masking
   lines_t wmask;
   lines_t wset;

   // per-line pad drive before it is packed into the carrier
   lines_t drv_val;
   lines_t drv_en;

   // handshake decode
   logic req_any;
   logic take;
   logic wr_hit;
   logic rd_load;
   logic rd_done;

   // read word chosen from the current register contents
   logic [31:0] rd_word;

   // change capture helpers
   logic clr_read;
   lines_t edge_seen;
   lines_t change_kept;
   lines_t change_next;

   // lines on which a direct output write may land
   lines_t dw_write_mask;

   // byte lanes widen into a per-bit write mask
   always_comb
   begin
      wmask = {{8{bus_req.byteenable[3]}}, {8{bus_req.byteenable[2]}},
               {8{bus_req.byteenable[1]}}, {8{bus_req.byteenable[0]}}};
      wset = bus_req.writedata & wmask;
   end

   // handshake: a request is taken while idle and answered one cycle on;
   // writes land at the answer edge, the edge at which the master sees
   // waitrequest low, so an abandoned write never changes state
   assign req_any = bus_req.read || bus_req.write;
   assign take = req_any && (s_q.bus == BUS_IDLE);
   assign wr_hit = bus_req.write && (s_q.bus == BUS_DONE);
   assign rd_load = bus_req.read && (s_q.bus == BUS_IDLE);
   assign rd_done = bus_req.read && (s_q.bus == BUS_DONE);
   assign waitrequest = req_any && (s_q.bus != BUS_DONE);

   // read multiplexer; sampled into a register at the take edge so the
   // word already stands from flops when waitrequest drops
   always_comb
   begin
      unique case (bus_req.address)
         `LINE_IRQ_MASK_OFS:
         begin
            rd_word = s_q.irq_mask; // R2
         end
         `LINE_CHANGE_STATUS_OFS:
         begin
            rd_word = s_q.change; // R3
         end
         `OPEN_DRAIN_STATE_OFS:
         begin
            rd_word = s_q.open_drain; // R7
         end
         `PULLUP_STATE_OFS:
         begin
            // stored as disabled-bits, so it reads with inverted sense
            rd_word = s_q.pullup_off; // R10
         end
         `FUNCTION_ASSIGNMENT_STATE_OFS:
         begin
            rd_word = s_q.func_b; // R13
         end
         `DIRECT_WRITE_STATE_OFS:
         begin
            rd_word = s_q.dw_en; // R16
         end
         `OUTPUT_DATA_STATE_OFS:
         begin
            rd_word = s_q.out_data;
         end
         default:
         begin
            // write-only and unmapped offsets read as zero
            rd_word = `UNMAPPED_READ;
         end
      endcase
   end

   // change capture: a level difference between the two newest samples
   always_comb
   begin
      edge_seen = s_q.sync2 ^ s_q.prev; // R3
   end

   // clear on read takes away only what the read reported; a change
   // that lands between the take and the answer edge is kept
   always_comb
   begin
      clr_read = rd_done && (bus_req.address == `LINE_CHANGE_STATUS_OFS);
      if (clr_read)
      begin
         change_kept = s_q.change & ~s_q.readdata; // R4
      end
      else
      begin
         change_kept = s_q.change;
      end
      // set wins over the clear in the same cycle
      change_next = change_kept | edge_seen; // R3
   end

   // output data lines open to direct writes
   always_comb
   begin
      dw_write_mask = wmask & s_q.dw_en; // R14 R15
   end

   // next state of every register of the block
   always_comb
   begin
      s_d = s_q;

      // two flops of synchroniser, then the compare sample
      s_d.sync1 = pad_in;
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;

      // bus sequencer: idle, then one answer cycle
      s_d.bus = BUS_IDLE;
      if (take)
      begin
         s_d.bus = BUS_DONE;
      end

      // latched change bits
      s_d.change = change_next;

      // register writes at the answer edge
      if (wr_hit)
      begin
         unique case (bus_req.address)
            `LINE_IRQ_ENABLE_OFS:
            begin
               s_d.irq_mask = s_q.irq_mask | wset; // R17 R18
            end
            `LINE_IRQ_DISABLE_OFS:
            begin
               s_d.irq_mask = s_q.irq_mask & ~wset; // R1 R18
            end
            `OPEN_DRAIN_ENABLE_OFS:
            begin
               s_d.open_drain = s_q.open_drain | wset; // R5 R18
            end
            `OPEN_DRAIN_DISABLE_OFS:
            begin
               s_d.open_drain = s_q.open_drain & ~wset; // R6 R18
            end
            `PULLUP_DISABLE_OFS:
            begin
               s_d.pullup_off = s_q.pullup_off | wset; // R8 R18
            end
            `PULLUP_ENABLE_OFS:
            begin
               s_d.pullup_off = s_q.pullup_off & ~wset; // R9 R18
            end
            `FIRST_FUNCTION_SELECT_OFS:
            begin
               s_d.func_b = s_q.func_b & ~wset; // R11 R18
            end
            `SECOND_FUNCTION_SELECT_OFS:
            begin
               s_d.func_b = s_q.func_b | wset; // R12 R18
            end
            `DIRECT_WRITE_ENABLE_OFS:
            begin
               s_d.dw_en = s_q.dw_en | wset; // R14 R18
            end
            `DIRECT_WRITE_DISABLE_OFS:
            begin
               s_d.dw_en = s_q.dw_en & ~wset; // R15 R18
            end
            `OUTPUT_DATA_STATE_OFS:
            begin
               // only write-enabled lines take the new level
               s_d.out_data = (s_q.out_data & ~dw_write_mask) |
                              (bus_req.writedata & dw_write_mask); // R14
            end
            default:
            begin
               // unmapped or read-only: ignored
               s_d.out_data = s_q.out_data;
            end
         endcase
      end

      // read word captured at the take edge, held until the next read
      if (rd_load)
      begin
         s_d.readdata = rd_word;
      end

      // level interrupt from the values about to be registered
      s_d.irq = |(s_d.change & s_d.irq_mask); // R19

      // synchronous reset overrides everything above
      if (sys_rst)
      begin
         s_d = '0;
         s_d.bus = BUS_IDLE;
         s_d.change = `RST_ZERO; // R4
         s_d.pullup_off = `RST_ZERO; // pull-ups on out of reset
      end
   end

   // the only register process; every flop of the block lives in s_q
   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   // per-line pad drive: peripheral owns lines it claims, else output data
   genvar gi;
   generate
      for (gi = 0; gi < LINES; gi++)
      begin : g_line
         logic val;
         logic en;
         always_comb
         begin
            if (periph_sel[gi])
            begin
               val = s_q.func_b[gi] ? periph_b_out[gi] : periph_a_out[gi];
               en = s_q.func_b[gi] ? periph_b_oe[gi] : periph_a_oe[gi];
            end
            else
            begin
               val = s_q.out_data[gi];
               en = 1'b1;
            end
            drv_val[gi] = val;
            // open-drain lines release instead of driving high
            drv_en[gi] = en && !(s_q.open_drain[gi] && val); // R7
         end
      end
   endgenerate

   // pad carrier; pull-up and function come straight from flops
   assign pad_ctl.pad_out = drv_val;
   assign pad_ctl.pad_oe = drv_en;
   assign pad_ctl.pullup_on = ~s_q.pullup_off; // R10
   assign pad_ctl.func_second = s_q.func_b; // R13

   // synchronised pin view for the rest of the chip
   assign line_level = s_q.sync2;

   // bus read word and interrupt, both registered
   assign readdata = s_q.readdata;
   assign irq = s_q.irq; // R19

   // limitation: the pad drive above is combinational from peripheral
   // inputs, so a peripheral glitch reaches the pad without filtering

endmodule : pio_line_ctrl

// [shared/pio_line_map.svh]
/*
 register offsets, reset values and widths for the line control block.
 assumes byte addressing on a 32-bit avalon-mm slave, one word per register.
*/
`ifndef PIO_LINE_MAP_SVH
`define PIO_LINE_MAP_SVH
`define LINE_IRQ_ENABLE_OFS 8'h00
`define LINE_IRQ_DISABLE_OFS 8'h04
`define LINE_IRQ_MASK_OFS 8'h08
`define LINE_CHANGE_STATUS_OFS 8'h0c
`define OPEN_DRAIN_ENABLE_OFS 8'h10
`define OPEN_DRAIN_DISABLE_OFS 8'h14
`define OPEN_DRAIN_STATE_OFS 8'h18
`define PULLUP_DISABLE_OFS 8'h1c
`define PULLUP_ENABLE_OFS 8'h20
`define PULLUP_STATE_OFS 8'h24
`define FIRST_FUNCTION_SELECT_OFS 8'h28
`define SECOND_FUNCTION_SELECT_OFS 8'h2c
`define FUNCTION_ASSIGNMENT_STATE_OFS 8'h30
`define DIRECT_WRITE_ENABLE_OFS 8'h34
`define DIRECT_WRITE_DISABLE_OFS 8'h38
`define DIRECT_WRITE_STATE_OFS 8'h3c
`define OUTPUT_DATA_STATE_OFS 8'h40
`define ADDR_W 8
`define LINES 32
`define RST_ZERO 32'h0000_0000
`define RST_ONES 32'hffff_ffff
`define UNMAPPED_READ 32'h0000_0000
`endif

// [shared/pio_line_pkg.sv]
/*
 types for the line control block: bus carrier, pad carrier, state record.
 assumes pio_line_map.svh is on the include path.
*/
`include "pio_line_map.svh"
package pio_line_pkg;
   typedef logic [`LINES-1:0] lines_t;

   // avalon-mm request from the master
   typedef struct packed {
      logic [`ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } bus_req_t;

   // pad controls towards the i/o ring
   typedef struct packed {
      lines_t pad_out;
      lines_t pad_oe;
      lines_t pullup_on;
      lines_t func_second;
   } pad_ctl_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DONE = 2'b10
   } bus_state_t;

   // whole state of the block
   typedef struct packed {
      bus_state_t bus;
      logic [31:0] readdata;
      lines_t irq_mask;
      lines_t change;
      lines_t open_drain;
      lines_t pullup_off;
      lines_t func_b;
      lines_t dw_en;
      lines_t out_data;
      lines_t sync1;
      lines_t sync2;
      lines_t prev;
      logic irq;
   } state_t;
endpackage : pio_line_pkg

// [verif/pio_line_monitor.sv]
/* assertions on the line control block ports.
 assumes a bind onto pio_line_ctrl, one clock, synchronous reset. */
`timescale 1ns/10ps
module pio_line_monitor
   import pio_line_pkg::*;
(
   input logic clk,
   input logic sys_rst,
   input bus_req_t bus_req,
   input logic [31:0] readdata,
   input logic waitrequest,
   input pad_ctl_t pad_ctl,
   input logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic wd;
   logic rd;
   lines_t d;
   // answered requests; writes full words only, partial lanes mask bits
   assign wd = bus_req.write && !waitrequest && &bus_req.byteenable;
   assign rd = bus_req.read && !waitrequest;
   assign d = bus_req.writedata;
   a_req_answer: assert property (
      (bus_req.read || bus_req.write) && waitrequest |=> !waitrequest)
      else $error("bus answer late");
   a_pullup_off: assert property (
      wd && bus_req.address == 8'h1c |=> (pad_ctl.pullup_on & $past(d)) == 0)
      else $error("pull-up still on");
   a_pullup_on: assert property (
      wd && bus_req.address == 8'h20 |=> &(pad_ctl.pullup_on | ~$past(d)))
      else $error("pull-up still off");
   a_first_func: assert property (
      wd && bus_req.address == 8'h28 |=> (pad_ctl.func_second & $past(d)) == 0)
      else $error("first function not taken");
   a_second_func: assert property (
      wd && bus_req.address == 8'h2c |=> &(pad_ctl.func_second | ~$past(d)))
      else $error("second function not taken");
   a_func_hold: assert property (
      !(bus_req.write && bus_req.address inside {8'h28, 8'h2c})
      |=> $stable(pad_ctl.func_second)) else $error("function moved");
   a_mask_gates: assert property (
      rd && bus_req.address == 8'h08 && readdata == 0 |-> !irq)
      else $error("irq with all lines masked");
   a_reset_state: assert property (disable iff (1'b0)
      sys_rst |=> !irq && &pad_ctl.pullup_on && pad_ctl.func_second == 0)
      else $error("reset state wrong");
   // main scenarios reached
   cover property (rd && bus_req.address == 8'h0c && readdata != 0);
   cover property ($rose(irq));
   cover property (wd && bus_req.address == 8'h40);
endmodule : pio_line_monitor

// [verif/pad_ring_model.sv]
/* pad ring and board model for the line control block.
 assumes pad controls from the block; the bench may hold lines itself. */
`timescale 1ns/10ps
module pad_ring_model
   import pio_line_pkg::*;
(
   input logic clk,
   input pad_ctl_t pad_ctl,
   input lines_t ext_en,
   input lines_t ext_val,
   output lines_t pad_in
);
   lines_t float_q = '0;
   // an undriven line without pull-up wanders rather than keep a value
   always_ff @(posedge clk)
   begin
      float_q <= ~float_q;
   end
   // board drive wins, then the pad driver, then pull-up or float
   assign pad_in = (ext_en & ext_val)
      | (~ext_en & pad_ctl.pad_oe & pad_ctl.pad_out)
      | (~ext_en & ~pad_ctl.pad_oe & (pad_ctl.pullup_on | float_q));
endmodule : pad_ring_model

// [verif/testbench.sv]
/* self-checking bench for the line control block.
 assumes a 20 MHz clock and one-word avalon-mm registers. */
`timescale 1ns/10ps
module testbench
   import pio_line_pkg::*;
;
   logic clk = 0;
   logic sys_rst = 1;
   bus_req_t bus_req = '0;
   logic [31:0] readdata;
   logic [31:0] rd_v;
   logic waitrequest;
   logic irq;
   pad_ctl_t pad_ctl;
   lines_t pad_in, pa_o, pa_e, pb_o, pb_e, sel, m;
   lines_t ext_en = '1;
   lines_t ext_v = '0;
   lines_t out_m = '0;
   lines_t st [5] = '{default: '0};
   logic [7:0] en_a [5] = '{8'h00, 8'h10, 8'h1c, 8'h2c, 8'h34};
   logic [7:0] dis_a [5] = '{8'h04, 8'h14, 8'h20, 8'h28, 8'h38};
   logic [7:0] st_a [5] = '{8'h08, 8'h18, 8'h24, 8'h30, 8'h3c};
   int err_total = 0, tests_run = 0, seed = 49, i, k;
   pio_line_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
      .readdata(readdata), .waitrequest(waitrequest), .pad_in(pad_in),
      .periph_a_out(pa_o), .periph_a_oe(pa_e), .periph_b_out(pb_o),
      .periph_b_oe(pb_e), .periph_sel(sel), .pad_ctl(pad_ctl),
      .line_level(), .irq(irq));
   pad_ring_model u_pads (.clk(clk), .pad_ctl(pad_ctl), .ext_en(ext_en),
      .ext_val(ext_v), .pad_in(pad_in));
   task automatic finish_test;
      $display("tests %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic check(input lines_t got, input lines_t exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // one word; waitrequest sampled at each rising edge, read data once it is low
   task automatic bus(input logic w, input logic [7:0] a, input lines_t d);
      int n;
      n = 0;
      bus_req <= '{a, !w, w, 4'hf, d};
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 20)
      begin
         err_total++;
         finish_test();
      end
      rd_v = readdata;
      bus_req <= '0;
      @(posedge clk);
   endtask : bus
   initial
   begin
      forever #25 clk = ~clk;
   end
   initial
   begin
      {pa_o, pa_e, pb_o, pb_e, sel} = '0;
      repeat (4) @(posedge clk);
      sys_rst <= 0;
      @(posedge clk);
      // reset values and an unmapped hole
      for (k = 0; k < 5; k++)
      begin
         bus(0, st_a[k], 0);
         check(rd_v, 0);
      end
      bus(0, 8'h80, 0);
      check(rd_v, 0);
      // random set and clear, a write to the read-only view, output data
      for (i = 0; i < 60; i++)
      begin
         k = {$random(seed)} % 5;
         m = $random(seed);
         {pa_o, pa_e, pb_o, pb_e} <= {$random(seed), $random(seed),
            $random(seed), $random(seed)};
         sel <= $random(seed);
         if (m[0])
            bus(1, en_a[k], m);
         else
            bus(1, dis_a[k], m);
         st[k] = m[0] ? st[k] | m : st[k] & ~m;
         bus(1, st_a[k], ~st[k]);
         bus(0, st_a[k], 0);
         check(rd_v, st[k]);
         m = $random(seed);
         bus(1, 8'h40, m);
         out_m = (out_m & ~st[4]) | (m & st[4]);
         bus(0, 8'h40, 0);
         check(rd_v, out_m);
      end
      // pin changes latch, raise irq through the mask, clear on read
      bus(0, 8'h0c, 0);
      m = $random(seed);
      ext_v <= ext_v ^ m;
      repeat (6) @(posedge clk);
      check(irq, |(m & st[0]));
      bus(0, 8'h0c, 0);
      check(rd_v, m);
      bus(0, 8'h0c, 0);
      check(rd_v, 0);
      check(irq, 0);
      finish_test();
   end
endmodule : testbench
bind pio_line_ctrl pio_line_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
   .bus_req(bus_req), .readdata(readdata), .waitrequest(waitrequest),
   .pad_ctl(pad_ctl), .irq(irq));
